// *** verilog/partner_ability_reg.sv ***
// link partner ability capture: registers the pages a remote
// partner sent during auto-negotiation, readable over AHB-Lite
// assumes the negotiation engine runs on hclk and hands over
// decoded burst words with single-cycle strobes
// What this block does
// - capture partner word, read-only at index 0x05
// - next page replaces base view after completion
// - bit 15 shows partner next page request
// - bit 14 shows partner acknowledge
// - acknowledge follows each incoming pulse burst
// - bit 13 shows partner remote fault
// - bit 12 reserved, reads zero in the base view
// - bit 11 shows asymmetric pause ability
// - bit 10 shows symmetric pause ability
// - bit 9 shows 100BASE-T4 ability
// - bit 8 shows 100BASE-TX full duplex
// - bit 7 shows 100BASE-TX half duplex
// - bit 6 shows 10BASE-T full duplex
// - bit 5 shows 10BASE-T half duplex
// - bits 4:0 selector, reset to zero
// - next view bit 13 is message page
// - next view bit 12 is comply flag
// - next view bits 10:0 code, reset zero
module partner_ability_reg (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // negotiation engine
  input  wire logic        flp_word_valid,
  input  wire logic [15:0] flp_word,
  input  wire logic        page_received,
  input  wire logic        page_is_next,
  input  wire logic        an_complete,
  input  wire logic        an_restart,
  // status toward the engine
  output logic             next_page_enable,
  output logic             view_is_next
);

  // ==========================================================
  // state
  typedef struct packed {
    lpa_pkg::base_page_type base;
    lpa_pkg::next_page_type next;
    lpa_pkg::view_type      view;
    logic                   np_enable;
    logic                   next_valid;
    logic [7:0]             page_count;
    logic [31:0]            rdata;
  } lpa_state_type;

  lpa_state_type          st_ff;
  lpa_state_type          nxt_st;
  lpa_pkg::bus_req_type   rd_req;
  lpa_pkg::bus_req_type   wr_req;
  logic [15:0]            view_word;
  logic                   ctrl_write;
  logic                   clear_req;
  logic                   np_in_use;

  // ==========================================================
  // helpers
  function automatic lpa_pkg::base_page_type to_base(input logic [15:0] w);
    lpa_pkg::base_page_type b;
    b          = w;
    b.reserved = 1'b0;
    return b;
  endfunction : to_base

  function automatic logic [31:0] read_mux(input logic [7:0] idx,
                                           input logic [15:0] word,
                                           input lpa_state_type s);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (idx == lpa_pkg::PARTNER_ABILITY_IDX) begin
      d[15:0] = word;
    end else if (idx == lpa_pkg::CTRL_IDX) begin
      d[lpa_pkg::CTRL_NP_BIT] = s.np_enable;
    end else if (idx == lpa_pkg::STATUS_IDX) begin
      d[0]    = s.view;
      d[1]    = s.next_valid;
      d[15:8] = s.page_count;
    end
    return d;
  endfunction : read_mux

  // ==========================================================
  // submodules
  lpa_ahb_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rd_req    (rd_req),
    .wr_req    (wr_req)
  );

  lpa_view_format u_view (
    .base      (st_ff.base),
    .next      (st_ff.next),
    .view      (st_ff.view),
    .view_word (view_word)
  );

  // ==========================================================
  // control decode
  assign ctrl_write = wr_req.wr && (wr_req.index == lpa_pkg::CTRL_IDX);
  assign clear_req  = ctrl_write && hwdata[lpa_pkg::CTRL_CLR_BIT];
  // next pages count only when both ends asked for them
  assign np_in_use  = st_ff.base.more_pages_request && st_ff.np_enable && st_ff.next_valid;

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;

    // software side first, so a capture in the same cycle wins
    if (ctrl_write) begin
      nxt_st.np_enable = hwdata[lpa_pkg::CTRL_NP_BIT];
    end
    if (clear_req) begin
      nxt_st.base       = lpa_pkg::BASE_RESET;
      nxt_st.next       = lpa_pkg::NEXT_RESET;
      nxt_st.view       = lpa_pkg::VIEW_BASE;
      nxt_st.next_valid = 1'b0;
      nxt_st.page_count = 8'h00;
    end
    // writes to the ability index fall through untouched

    // acknowledge tracks every burst, even before a page is confirmed
    if (flp_word_valid) begin
      if (page_is_next) begin
        nxt_st.next.partner_ack = flp_word[lpa_pkg::ACK_BIT];
      end else begin
        nxt_st.base.partner_ack = flp_word[lpa_pkg::ACK_BIT];
      end
    end

    if (page_received) begin
      nxt_st.page_count = st_ff.page_count + 8'h01;
      if (page_is_next) begin
        nxt_st.next       = flp_word;
        nxt_st.next_valid = 1'b1;
      end else begin
        nxt_st.base       = to_base(flp_word);
        nxt_st.view       = lpa_pkg::VIEW_BASE;
        nxt_st.next_valid = 1'b0;
      end
    end

    if (an_complete && np_in_use) begin
      nxt_st.view = lpa_pkg::VIEW_NEXT;
    end
    if (an_restart) begin
      nxt_st.view       = lpa_pkg::VIEW_BASE;
      nxt_st.next_valid = 1'b0;
    end

    // read data is latched in the address phase, ready for the data phase
    if (rd_req.rd) begin
      nxt_st.rdata = read_mux(rd_req.index, view_word, st_ff);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff.base       <= lpa_pkg::BASE_RESET;
      st_ff.next       <= lpa_pkg::NEXT_RESET;
      st_ff.view       <= lpa_pkg::VIEW_BASE;
      st_ff.np_enable  <= lpa_pkg::NP_EN_RESET;
      st_ff.next_valid <= 1'b0;
      st_ff.page_count <= 8'h00;
      st_ff.rdata      <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign hrdata           = st_ff.rdata;
  assign next_page_enable = st_ff.np_enable;
  assign view_is_next     = (st_ff.view == lpa_pkg::VIEW_NEXT);

  // ==========================================================
  // checks
  a_base_capture_word: assert property (
    @(posedge hclk) disable iff (!hresetn)
    page_received && !page_is_next
    |=> st_ff.base == to_base($past(flp_word)) && st_ff.view == lpa_pkg::VIEW_BASE)
    else $error("base page not captured");

  a_read_returns_view: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_req.rd && rd_req.index == lpa_pkg::PARTNER_ABILITY_IDX
    |=> hrdata[15:0] == $past(view_word) && hrdata[31:16] == 16'h0000)
    else $error("ability read returned wrong word");

  a_next_view_switch: assert property (
    @(posedge hclk) disable iff (!hresetn)
    an_complete && np_in_use && !an_restart
    |=> view_is_next && view_word == st_ff.next)
    else $error("next page view not taken after completion");

  a_np_bit_both_views: assert property (
    @(posedge hclk) disable iff (!hresetn)
    view_word[lpa_pkg::NP_BIT] == (view_is_next ? st_ff.next.more_pages_request
                                                : st_ff.base.more_pages_request))
    else $error("next page request bit wrong");

  a_ack_follows_burst: assert property (
    @(posedge hclk) disable iff (!hresetn)
    flp_word_valid && !page_is_next
    |=> st_ff.base.partner_ack == $past(flp_word[lpa_pkg::ACK_BIT]))
    else $error("acknowledge did not follow the burst");

  a_ack_read_value: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !view_is_next |-> view_word[lpa_pkg::ACK_BIT] == st_ff.base.partner_ack)
    else $error("acknowledge bit not visible");

  a_base_fault_pause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !view_is_next |-> view_word[lpa_pkg::RF_BIT] == st_ff.base.remote_fault_flag
      && view_word[lpa_pkg::ASYM_BIT] == st_ff.base.asymmetric_pause_ability
      && view_word[lpa_pkg::PAUSE_BIT] == st_ff.base.symmetric_pause_ability)
    else $error("fault or pause bits wrong");

  a_reserved_reads_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(page_received) && !page_is_next
    |=> !view_is_next && view_word[lpa_pkg::RSVD_BIT] == 1'b0)
    else $error("reserved bit read as one");

  a_tech_bits_match: assert property (
    @(posedge hclk) disable iff (!hresetn)
    page_received && !page_is_next && !an_complete
    |=> view_word[lpa_pkg::TECH_MSB:0] == $past(flp_word[lpa_pkg::TECH_MSB:0]))
    else $error("technology or selector bits wrong");

  a_reset_all_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !$past(hresetn) |-> view_word == 16'h0000 && st_ff.next == lpa_pkg::NEXT_RESET)
    else $error("pages not zero after reset");

  a_next_fields_seen: assert property (
    @(posedge hclk) disable iff (!hresetn)
    view_is_next |-> view_word[lpa_pkg::MSG_BIT] == st_ff.next.message_page_flag
      && view_word[lpa_pkg::COMPLY_BIT] == st_ff.next.partner_comply_flag
      && view_word[lpa_pkg::CODE_MSB:0] == st_ff.next.code)
    else $error("next page fields wrong");

  a_write_ignored: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_req.wr && wr_req.index == lpa_pkg::PARTNER_ABILITY_IDX && !flp_word_valid && !page_received
    |=> st_ff.base == $past(st_ff.base) && st_ff.next == $past(st_ff.next))
    else $error("write changed the ability register");

  a_bus_always_ready: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus not ready or not okay");

  a_unmapped_reads_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_req.rd && rd_req.index != lpa_pkg::PARTNER_ABILITY_IDX && rd_req.index != lpa_pkg::CTRL_IDX
      && rd_req.index != lpa_pkg::STATUS_IDX
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped index read nonzero");

  a_page_count_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    page_received |=> st_ff.page_count == $past(st_ff.page_count) + 8'h01)
    else $error("page count did not step");

  // clear and capture in one cycle: the capture wins
  a_capture_beats_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clear_req && page_received && !page_is_next
    |=> st_ff.base == to_base($past(flp_word)))
    else $error("clear overrode a base page capture");

  a_ctrl_write_np: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctrl_write |=> st_ff.np_enable == $past(hwdata[lpa_pkg::CTRL_NP_BIT]))
    else $error("next page enable not written");

  a_ctrl_read_back: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_req.rd && rd_req.index == lpa_pkg::CTRL_IDX
    |=> hrdata == {31'h0000_0000, $past(st_ff.np_enable)})
    else $error("control read returned wrong value");

  a_status_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_req.rd && rd_req.index == lpa_pkg::STATUS_IDX
    |=> hrdata == {16'h0000, $past(st_ff.page_count), 6'h00, $past(st_ff.next_valid), $past(view_is_next)})
    else $error("status read returned wrong value");

  a_np_needs_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    an_complete && !np_in_use && !an_restart && !page_received && !clear_req
    |=> st_ff.view == $past(st_ff.view))
    else $error("view changed without next pages in use");

  a_next_view_holds: assert property (
    @(posedge hclk) disable iff (!hresetn)
    view_is_next && !an_restart && !clear_req && !(page_received && !page_is_next)
    |=> view_is_next)
    else $error("next page view dropped without cause");

  a_restart_base_view: assert property (
    @(posedge hclk) disable iff (!hresetn)
    an_restart |=> !view_is_next && !st_ff.next_valid)
    else $error("restart did not return to base view");

  a_next_capture_word: assert property (
    @(posedge hclk) disable iff (!hresetn)
    page_received && page_is_next && !an_restart
    |=> st_ff.next == $past(flp_word) && st_ff.next_valid)
    else $error("next page not captured");

  a_next_ack_burst: assert property (
    @(posedge hclk) disable iff (!hresetn)
    flp_word_valid && page_is_next
    |=> st_ff.next.partner_ack == $past(flp_word[lpa_pkg::ACK_BIT]))
    else $error("next page acknowledge did not follow the burst");

  a_clear_zeroes: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clear_req && !flp_word_valid && !page_received && !an_complete
    |=> st_ff.base == lpa_pkg::BASE_RESET && st_ff.next == lpa_pkg::NEXT_RESET
      && !view_is_next && st_ff.page_count == 8'h00)
    else $error("clear left captured state");

endmodule : partner_ability_reg

// *** common/lpa_pkg.sv ***
// package for the link partner ability capture block
// assumes one hclk domain and an AHB-Lite bus with 32-bit data
package lpa_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0]  PARTNER_ABILITY_IDX = 8'h05;
  localparam logic [7:0]  CTRL_IDX            = 8'h10;
  localparam logic [7:0]  STATUS_IDX          = 8'h11;

  // ==========================================================
  // field positions of the ability word and the control register
  localparam int unsigned NP_BIT      = 15;
  localparam int unsigned ACK_BIT     = 14;
  localparam int unsigned RF_BIT      = 13;
  localparam int unsigned RSVD_BIT    = 12;
  localparam int unsigned ASYM_BIT    = 11;
  localparam int unsigned PAUSE_BIT   = 10;
  localparam int unsigned TECH_MSB    = 9;
  localparam int unsigned TECH_LSB    = 5;
  localparam int unsigned SEL_MSB     = 4;
  localparam int unsigned MSG_BIT     = 13;
  localparam int unsigned COMPLY_BIT  = 12;
  localparam int unsigned CODE_MSB    = 10;
  localparam int unsigned CTRL_NP_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;

  // ==========================================================
  // reset values and the NONSEQ transfer code
  localparam logic [15:0] BASE_RESET  = 16'h0000;
  localparam logic [15:0] NEXT_RESET  = 16'h0000;
  localparam logic        NP_EN_RESET = 1'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  // ==========================================================
  // carriers
  typedef enum logic {VIEW_BASE = 1'b0, VIEW_NEXT = 1'b1} view_type;

  typedef struct packed {
    logic       more_pages_request;
    logic       partner_ack;
    logic       remote_fault_flag;
    logic       reserved;
    logic       asymmetric_pause_ability;
    logic       symmetric_pause_ability;
    logic       four_pair_100_ability;
    logic       fast_full_duplex_ability;
    logic       fast_half_duplex_ability;
    logic       ten_full_duplex_ability;
    logic       ten_half_duplex_ability;
    logic [4:0] selector;
  } base_page_type;

  typedef struct packed {
    logic        more_pages_request;
    logic        partner_ack;
    logic        message_page_flag;
    logic        partner_comply_flag;
    logic        toggle;
    logic [10:0] code;
  } next_page_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] index;
  } bus_req_type;

endpackage : lpa_pkg

// *** verilog/lpa_ahb_port.sv ***
// AHB-Lite address and data phase tracking for the register bank
// assumes a single slave, zero wait states, whole-word accesses
module lpa_ahb_port (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // bus
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  // toward the register bank
  output lpa_pkg::bus_req_type    rd_req,
  output lpa_pkg::bus_req_type    wr_req
);

  // ==========================================================
  // address phase
  logic                 accept;
  lpa_pkg::bus_req_type st_ff;
  lpa_pkg::bus_req_type nxt_st;

  // sequential transfers are not used, only NONSEQ is taken
  assign accept = hsel && hready && (htrans == lpa_pkg::HTRANS_NONSEQ);

  always_comb begin
    rd_req.rd    = accept && !hwrite;
    rd_req.wr    = 1'b0;
    rd_req.index = haddr[9:2];
    nxt_st.rd    = 1'b0;
    nxt_st.wr    = accept && hwrite;
    nxt_st.index = haddr[9:2];
  end

  // ==========================================================
  // data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wr_req    = st_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : lpa_ahb_port

// *** verilog/lpa_view_format.sv ***
// builds the 16-bit word software sees at the ability offset
// assumes captured pages arrive already unpacked
module lpa_view_format (
  // captured pages
  input  lpa_pkg::base_page_type  base,
  input  lpa_pkg::next_page_type  next,
  input  lpa_pkg::view_type       view,
  // visible word
  output logic [15:0]             view_word
);

  // ==========================================================
  // view select
  always_comb begin
    if (view == lpa_pkg::VIEW_NEXT) begin
      view_word = next;
    end else begin
      view_word = base;
      view_word[lpa_pkg::RSVD_BIT] = 1'b0;
    end
  end

endmodule : lpa_view_format

// *** tb/lp_far_model.sv ***
// model of the remote partner as seen through the negotiation engine
// assumes hclk is free running; words are single-cycle strobes
module lp_far_model (
  // clock
  input  wire logic   hclk,
  // toward the capture block
  output logic        flp_word_valid,
  output logic [15:0] flp_word,
  output logic        page_received,
  output logic        page_is_next,
  output logic        an_complete,
  output logic        an_restart
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    flp_word_valid = 1'b0;
    flp_word       = 16'h0000;
    page_received  = 1'b0;
    page_is_next   = 1'b0;
    an_complete    = 1'b0;
    an_restart     = 1'b0;
  end

  // ==========================================================
  // one burst word; gap idles first so a slow partner can be played
  task send(input logic [15:0] w, input logic nxt, input logic conf, input int gap);
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    flp_word_valid <= 1'b1;
    page_received  <= conf;
    page_is_next   <= nxt;
    flp_word       <= w;
    @(posedge hclk);
    flp_word_valid <= 1'b0;
    page_received  <= 1'b0;
    // no word on the line: show the inverse so a stale capture shows up
    flp_word       <= ~w;
  endtask : send

  // done high: negotiation succeeded, else restarted
  task pulse(input logic done);
    @(posedge hclk);
    an_complete <= done;
    an_restart  <= ~done;
    @(posedge hclk);
    an_complete <= 1'b0;
    an_restart  <= 1'b0;
  endtask : pulse
endmodule : lp_far_model

// *** tb/tb_link_partner_ability_capture.sv ***
// self-checking bench for the partner ability register
// assumes the AHB-Lite slave answers with zero wait states
module tb_link_partner_ability_capture;
  timeunit 1ns;
  timeprecision 100ps;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic flp_word_valid, page_received, page_is_next, an_complete, an_restart;
  logic [15:0] flp_word;
  logic next_page_enable, view_is_next;
  int n_fail, comparisons;

  partner_ability_reg dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flp_word_valid(flp_word_valid),
    .flp_word(flp_word), .page_received(page_received), .page_is_next(page_is_next),
    .an_complete(an_complete), .an_restart(an_restart), .next_page_enable(next_page_enable),
    .view_is_next(view_is_next));

  lp_far_model p (.hclk(hclk), .flp_word_valid(flp_word_valid), .flp_word(flp_word),
    .page_received(page_received), .page_is_next(page_is_next), .an_complete(an_complete),
    .an_restart(an_restart));

  // ==========================================================
  // checking and closing
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // bus master: address phase held until hready, then data phase
  task ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= lpa_pkg::HTRANS_NONSEQ;
    haddr  <= {22'h000000, idx, 2'h0};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hready", 32'h1, {31'h0, hreadyout});
  endtask : ahb

  task rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, idx, 32'h0000_0000, v);
    chk(name, exp, v);
  endtask : rd_chk

  task wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, idx, d, v);
  endtask : wr

  // ==========================================================
  // scenarios
  task t_reset;
    rd_chk("ability after reset", lpa_pkg::PARTNER_ABILITY_IDX, 32'h0000_0000);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    chk("np enable after reset", 32'h0, {31'h0, next_page_enable});
  endtask : t_reset

  // one bit set at a time, so a swapped or stuck field shows
  task t_fields;
    logic [15:0] w;
    logic [31:0] exp;
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      exp = {16'h0000, (i == 12) ? 16'h0000 : w};
      p.send(w, 1'b0, 1'b1, i % 3);
      rd_chk("base field", lpa_pkg::PARTNER_ABILITY_IDX, exp);
    end
    p.send(16'hFFFF, 1'b0, 1'b1, 0);
    rd_chk("base all ones", lpa_pkg::PARTNER_ABILITY_IDX, 32'h0000_EFFF);
  endtask : t_fields

  task t_ack_and_write;
    p.send(16'h01E1, 1'b0, 1'b1, 0);
    p.send(16'h4000, 1'b0, 1'b0, 1);
    rd_chk("ack from burst", lpa_pkg::PARTNER_ABILITY_IDX, 32'h0000_41E1);
    wr(lpa_pkg::PARTNER_ABILITY_IDX, 32'hFFFF_0000);
    rd_chk("write ignored", lpa_pkg::PARTNER_ABILITY_IDX, 32'h0000_41E1);
  endtask : t_ack_and_write

  // en: next page enable; without it completion keeps the base view
  task t_next(input logic en);
    logic [31:0] exp;
    wr(lpa_pkg::CTRL_IDX, {31'h0, en});
    // the enable flop updates on the edge that ends the write
    #1;
    chk("np enable", {31'h0, en}, {31'h0, next_page_enable});
    rd_chk("ctrl readback", lpa_pkg::CTRL_IDX, {31'h0, en});
    p.send(16'h8001, 1'b0, 1'b1, 0);
    p.send(16'hB955, 1'b1, 1'b1, 2);
    rd_chk("base before done", lpa_pkg::PARTNER_ABILITY_IDX, 32'h0000_8001);
    p.pulse(1'b1);
    #1;
    chk("view flag", {31'h0, en}, {31'h0, view_is_next});
    exp = en ? 32'h0000_B955 : 32'h0000_8001;
    rd_chk("after done", lpa_pkg::PARTNER_ABILITY_IDX, exp);
    p.pulse(1'b0);
    #1;
    chk("view after restart", 32'h0, {31'h0, view_is_next});
    rd_chk("base after restart", lpa_pkg::PARTNER_ABILITY_IDX, 32'h0000_8001);
  endtask : t_next

  // 22 confirmed pages so far; clear zeroes pages and count
  task t_clear;
    rd_chk("status", lpa_pkg::STATUS_IDX, 32'h0000_1600);
    wr(lpa_pkg::CTRL_IDX, 32'h0000_0002);
    rd_chk("ability after clear", lpa_pkg::PARTNER_ABILITY_IDX, 32'h0000_0000);
    rd_chk("status after clear", lpa_pkg::STATUS_IDX, 32'h0000_0000);
    rd_chk("ctrl after clear", lpa_pkg::CTRL_IDX, 32'h0000_0000);
  endtask : t_clear

  // ==========================================================
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    repeat (5000) @(posedge hclk);
    n_fail++;
    summarize;
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_fields;
    t_ack_and_write;
    t_next(1'b1);
    t_next(1'b0);
    t_clear;
    summarize;
  end
endmodule : tb_link_partner_ability_capture
